// *** pkg/clk_gate_pkg.sv ***
// constants, types and field helpers for the unit clock gating block
package clk_gate_pkg;

  // ********************************************************
  // register offsets (low 12 bits of the byte address)
  // ********************************************************
  localparam logic [11:0] RUN_GATE_OFS = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h120;
  localparam logic [11:0] CLK_CFG_OFS = 12'h140;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h150;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h154;

  // ********************************************************
  // field positions and reset values
  // ********************************************************
  localparam int CAN_BIT = 24;
  localparam int PWM_BIT = 20;
  localparam int ADC_BIT = 16;
  localparam int RATE_LSB = 8;
  localparam int WDOG_BIT = 3;
  localparam int AUTO_GATE_BIT = 0;
  localparam logic [31:0] GATE_RESET = 32'h0000_0040;
  localparam logic AUTO_GATE_RESET = 1'b0;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // ********************************************************
  // units, one bit each in enable, fault and irq vectors
  // ********************************************************
  localparam int NUM_UNITS = 4;
  localparam int UNIT_WDOG = 0;
  localparam int UNIT_ADC = 1;
  localparam int UNIT_PWM = 2;
  localparam int UNIT_CAN = 3;

  // ********************************************************
  // converter sample rate codes and their rates in ksps
  // ********************************************************
  localparam logic [1:0] RATE_125K = 2'h0;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_500K = 2'h2;
  localparam logic [9:0] KSPS_125 = 10'h07D;
  localparam logic [9:0] KSPS_250 = 10'h0FA;
  localparam logic [9:0] KSPS_500 = 10'h1F4;

  typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} pwr_e;

  typedef struct packed {
    logic can;
    logic pwm;
    logic adc;
    logic [1:0] rate;
    logic wdog;
  } gate_s;

  function automatic gate_s word_to_gate(input logic [31:0] w);
    gate_s g;
    g.can = w[CAN_BIT];
    g.pwm = w[PWM_BIT];
    g.adc = w[ADC_BIT];
    g.rate = w[RATE_LSB+1:RATE_LSB];
    g.wdog = w[WDOG_BIT];
    return g;
  endfunction : word_to_gate

  // reserved bits always come back as zero
  function automatic logic [31:0] gate_to_word(input gate_s g);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CAN_BIT] = g.can;
    w[PWM_BIT] = g.pwm;
    w[ADC_BIT] = g.adc;
    w[RATE_LSB+1:RATE_LSB] = g.rate;
    w[WDOG_BIT] = g.wdog;
    return w;
  endfunction : gate_to_word

endpackage : clk_gate_pkg

// *** tb/periph_clk_gate_assertions.sv ***
// port assertions for the unit clock gating block
`timescale 1ns/1ns
`default_nettype none
module periph_clk_gate_chk
  import clk_gate_pkg::*;
#(parameter logic [1:0] MAX_RATE = RATE_500K) (
  // bus
  input wire logic MCLK, RST, HSEL, HWRITE, HREADY,
  input wire logic [31:0] HADDR, HWDATA, HRDATA,
  input wire logic [1:0] HTRANS,
  // units
  input wire logic SLEEP_REQ, DEEP_SLEEP_REQ,
  input wire logic [NUM_UNITS-1:0] UNIT_ACCESS, UNIT_FAULT, UNIT_CLK_EN,
  input wire logic [1:0] ADC_RATE_SEL,
  input wire logic [9:0] ADC_RATE_KSPS
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire logic take = HSEL && HREADY && HTRANS[1];
  wire logic run = !SLEEP_REQ && !DEEP_SLEEP_REQ;
  wire logic [11:0] ofs = HADDR[11:0];
  wire logic gate_ofs = ofs inside {RUN_GATE_OFS, SLEEP_GATE_OFS,
                                    DEEP_GATE_OFS};
  wire logic [3:0] wen = {HWDATA[CAN_BIT], HWDATA[PWM_BIT],
                          HWDATA[ADC_BIT], HWDATA[WDOG_BIT]};
  sequence rd_gate_s; take && !HWRITE && gate_ofs; endsequence
  sequence wr_run_s; take && HWRITE && ofs == RUN_GATE_OFS && run; endsequence
  // power state is registered, so four quiet cycles let every update land
  sequence quiet_s;
    !(take && HWRITE) && $stable(SLEEP_REQ) && $stable(DEEP_SLEEP_REQ);
  endsequence
  AST_FAULT: assert property (
    UNIT_FAULT == (UNIT_ACCESS & ~UNIT_CLK_EN))
    else $error("fault differs from access to gated unit");
  AST_RATE_CAP: assert property (ADC_RATE_SEL <= MAX_RATE)
    else $error("applied rate above maximum");
  AST_KSPS: assert property (
    ADC_RATE_KSPS == (ADC_RATE_SEL == RATE_125K ? KSPS_125 :
    ADC_RATE_SEL == RATE_250K ? KSPS_250 : KSPS_500))
    else $error("rate decode wrong");
  AST_RST_OFF: assert property ($fell(RST) |-> UNIT_CLK_EN == '0)
    else $error("unit enabled after reset");
  AST_RESERVED: assert property (
    rd_gate_s |=> (HRDATA & 32'hFEEE_FCF7) == '0)
    else $error("reserved bits read nonzero");
  AST_RD_RATE: assert property (rd_gate_s |=> HRDATA[9:8] <= MAX_RATE)
    else $error("stored rate above maximum");
  AST_RUN_APPLY: assert property (
    wr_run_s ##1 run [*2] |=> UNIT_CLK_EN == $past(wen, 2))
    else $error("run gate write not applied");
  AST_HOLD: assert property (quiet_s [*4] |-> $stable(UNIT_CLK_EN))
    else $error("enables changed with no cause");
endmodule : periph_clk_gate_chk
bind periph_clk_gate periph_clk_gate_chk #(.MAX_RATE(MAX_RATE)) i_chk (.*);
`default_nettype wire

// *** tb/periph_clk_gate_bench.sv ***
// self-checking bench for the unit clock gating block
`timescale 1ns/1ns
`default_nettype none
module periph_clk_gate_bench
  import clk_gate_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic slp = 1'b0, dslp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [3:0] acc = 4'h0, oh;
  wire logic [31:0] hrdata;
  wire logic hrdy, hresp, irq;
  wire logic [3:0] fault, clk_en;
  wire logic [1:0] rsel;
  wire logic [9:0] ksps;
  int num_errors = 0, checks = 0, rate;
  int bitpos[4] = '{WDOG_BIT, ADC_BIT, PWM_BIT, CAN_BIT};
  logic [11:0] regs[6] = '{RUN_GATE_OFS, SLEEP_GATE_OFS, DEEP_GATE_OFS,
                           CLK_CFG_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS};
  logic [9:0] kt[3] = '{KSPS_125, KSPS_250, KSPS_500};

  always #10 mclk = ~mclk;

  periph_clk_gate i_dut (.MCLK(mclk), .RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(hresp), .SLEEP_REQ(slp), .DEEP_SLEEP_REQ(dslp),
    .UNIT_ACCESS(acc), .UNIT_FAULT(fault), .UNIT_CLK_EN(clk_en),
    .ADC_RATE_SEL(rsel), .ADC_RATE_KSPS(ksps), .IRQ(irq));

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge mclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(n, q, e);
  endtask : rdc
  task automatic pwr(input logic s, d);
    @(posedge mclk);
    slp <= s;
    dslp <= d;
    tick(3);
  endtask : pwr
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // whole run is under 200 cycles; allow 15000 cycles
  initial begin
    #300000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    foreach (regs[i]) rdc("reset reg", regs[i], 32'h0000_0000);
    chk("reset enables", clk_en, 32'h0000_0000);
    $display("test reset done");
    acc <= 4'hF;
    for (int u = 0; u < 4; u++) begin
      oh = 4'h1 << u;
      wr(RUN_GATE_OFS, 32'h1 << bitpos[u]);
      tick(2);
      chk("enable", clk_en, oh);
      chk("fault", fault, 4'(~oh));
      rdc("gate readback", RUN_GATE_OFS, 32'h1 << bitpos[u]);
    end
    wr(SLEEP_GATE_OFS, 32'hFFFF_FFFF);
    rdc("reserved", SLEEP_GATE_OFS, 32'h0111_0208);
    wr(12'h200, 32'hFFFF_FFFF);
    rdc("unmapped", 12'h200, 32'h0000_0000);
    chk("okay response", hresp, 32'h0000_0000);
    $display("test gating done");
    for (int r = 0; r < 4; r++) begin
      wr(RUN_GATE_OFS, r << RATE_LSB);
      tick(2);
      rate = (r > 2) ? 2 : r;
      rdc("rate field", RUN_GATE_OFS, rate << RATE_LSB);
      chk("rate code", rsel, rate);
      chk("rate ksps", ksps, kt[rate]);
    end
    $display("test rate done");
    wr(RUN_GATE_OFS, 32'h1 << WDOG_BIT);
    wr(SLEEP_GATE_OFS, 32'h1 << PWM_BIT);
    wr(DEEP_GATE_OFS, 32'h1 << CAN_BIT);
    for (int a = 0; a < 2; a++) begin
      wr(CLK_CFG_OFS, a);
      pwr(1'b1, 1'b0);
      chk("sleep enables", clk_en, a ? 4'h4 : 4'h1);
      pwr(1'b1, 1'b1);
      chk("deep enables", clk_en, a ? 4'h8 : 4'h1);
      pwr(1'b0, 1'b0);
      chk("run enables", clk_en, 4'h1);
    end
    $display("test power done");
    @(posedge mclk);
    acc <= 4'h0;
    wr(IRQ_STATUS_OFS, 32'h0000_000F);
    rdc("status clear", IRQ_STATUS_OFS, 32'h0000_0000);
    acc <= 4'h4;
    @(posedge mclk);
    acc <= 4'h0;
    tick(2);
    rdc("status", IRQ_STATUS_OFS, 32'h0000_0004);
    chk("irq masked", irq, 32'h0000_0000);
    wr(IRQ_MASK_OFS, 32'h0000_0004);
    tick(2);
    chk("irq raised", irq, 32'h0000_0001);
    wr(IRQ_STATUS_OFS, 32'h0000_0004);
    tick(2);
    chk("irq cleared", irq, 32'h0000_0000);
    $display("test irq done");
    rst <= 1'b1;
    tick(2);
    chk("enables in reset", clk_en, 32'h0000_0000);
    @(posedge mclk);
    rst <= 1'b0;
    rdc("deep after reset", DEEP_GATE_OFS, 32'h0000_0000);
    $display("test rerun reset done");
    tally_and_finish();
  end
endmodule : periph_clk_gate_bench
`default_nettype wire

// *** verilog/periph_clk_gate.sv ***
// unit clock gating control with AHB-Lite register slave
//
// What this block does
// - a unit gets its clock enable while its gate bit is one, else none.
// - access to a unit whose clock is gated off gets a fault answer.
// - all gate bits reset to zero, so every unit starts unclocked.
// - three gate registers: run, sleep, deep sleep, chosen by power state.
// - sleep and deep sleep registers apply only with auto gating set.
// - bit 24 gates the CAN unit; read/write, resets to zero.
// - bit 20 gates the PWM module; its accesses fault while unclocked.
// - bit 16 gates converter zero; its accesses fault while unclocked.
// - bit 3 gates the watchdog in every register; faults while unclocked.
// - rate field 9:8 gives 125K, 250K or 500K samples per second.
// - the stored sample rate never exceeds the supported maximum.
// - reserved bits are read-only and read as zero.
// - run register at 0x100, next to the sleep register at 0x110.
// - deep sleep register at 0x120, same layout and reset as sleep.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module periph_clk_gate
  import clk_gate_pkg::*;
#(
  parameter logic [1:0] MAX_RATE = RATE_500K
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // power state
  input wire logic SLEEP_REQ,
  input wire logic DEEP_SLEEP_REQ,
  // unit side
  input wire logic [NUM_UNITS-1:0] UNIT_ACCESS,
  output logic [NUM_UNITS-1:0] UNIT_FAULT,
  output logic [NUM_UNITS-1:0] UNIT_CLK_EN,
  output logic [1:0] ADC_RATE_SEL,
  output logic [9:0] ADC_RATE_KSPS,
  // interrupt
  output logic IRQ
);

  // ********************************************************
  // elaboration check
  // ********************************************************
  if (MAX_RATE > RATE_500K) begin : g_bad_rate
    $error("MAX_RATE above the highest defined rate code");
  end

  // ********************************************************
  // state
  // ********************************************************
  gate_s run_q, run_d;
  gate_s sleep_q, sleep_d;
  gate_s deep_q, deep_d;
  logic auto_q, auto_d;
  logic [NUM_UNITS-1:0] sts_q, sts_d;
  logic [NUM_UNITS-1:0] mask_q, mask_d;
  logic [NUM_UNITS-1:0] en_q;
  logic [1:0] rate_q;
  logic [9:0] ksps_q;
  logic [31:0] rdata_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  pwr_e pwr_q, pwr_d;

  // ********************************************************
  // bus decode
  // ********************************************************
  // only the low 12 bits select; HSEL covers the rest of the map
  wire logic addr_phase = HSEL & HREADY & HTRANS[1];
  wire logic [11:0] rd_addr = HADDR[11:0];
  wire logic wr_run = wr_pend_q && (wr_addr_q == RUN_GATE_OFS);
  wire logic wr_sleep = wr_pend_q && (wr_addr_q == SLEEP_GATE_OFS);
  wire logic wr_deep = wr_pend_q && (wr_addr_q == DEEP_GATE_OFS);
  wire logic wr_cfg = wr_pend_q && (wr_addr_q == CLK_CFG_OFS);
  wire logic wr_sts = wr_pend_q && (wr_addr_q == IRQ_STATUS_OFS);
  wire logic wr_mask = wr_pend_q && (wr_addr_q == IRQ_MASK_OFS);

  // ********************************************************
  // register next values
  // ********************************************************
  // writes above the supported rate are pulled down to it
  function automatic gate_s clamp_rate(input gate_s g);
    gate_s r;
    r = g;
    if (g.rate > MAX_RATE) begin
      r.rate = MAX_RATE;
    end
    return r;
  endfunction : clamp_rate

  // only the named fields are stored; reserved bits are dropped
  wire gate_s wr_gate = clamp_rate(word_to_gate(HWDATA));
  assign run_d = wr_run ? wr_gate : run_q;
  assign sleep_d = wr_sleep ? wr_gate : sleep_q;
  assign deep_d = wr_deep ? wr_gate : deep_q;
  assign auto_d = wr_cfg ? HWDATA[AUTO_GATE_BIT] : auto_q;
  assign mask_d = wr_mask ? HWDATA[NUM_UNITS-1:0] : mask_q;

  // ********************************************************
  // power state and applied gate register
  // ********************************************************
  assign pwr_d = DEEP_SLEEP_REQ ? PWR_DEEP :
                 SLEEP_REQ ? PWR_SLEEP : PWR_RUN;

  gate_s applied;
  always_comb begin
    applied = run_q;
    if (auto_q) begin
      case (pwr_q)
        PWR_SLEEP: applied = sleep_q;
        PWR_DEEP: applied = deep_q;
        PWR_RUN: applied = run_q;
        default: applied = run_q;
      endcase
    end
  end

  wire logic [NUM_UNITS-1:0] en_d = {applied.can, applied.pwm,
                                     applied.adc, applied.wdog};

  // ********************************************************
  // per-unit fault and sticky status
  // ********************************************************
  logic [NUM_UNITS-1:0] fault;
  genvar i;
  for (i = 0; i < NUM_UNITS; i++) begin : g_unit
    // gated unit answers with a fault
    assign fault[i] = UNIT_ACCESS[i] & ~en_q[i];
    // a new fault beats a same-cycle write-one-to-clear
    assign sts_d[i] = fault[i] |
                      (sts_q[i] & ~(wr_sts & HWDATA[i]));
  end

  // ********************************************************
  // rate decode
  // ********************************************************
  wire logic [9:0] ksps_d = (applied.rate == RATE_500K) ? KSPS_500 :
                            (applied.rate == RATE_250K) ? KSPS_250 :
                            KSPS_125;

  // ********************************************************
  // read mux
  // ********************************************************
  // built from next values so a read right after a write sees it
  wire logic [31:0] rd_word =
    (rd_addr == RUN_GATE_OFS) ? gate_to_word(run_d) :
    (rd_addr == SLEEP_GATE_OFS) ? gate_to_word(sleep_d) :
    (rd_addr == DEEP_GATE_OFS) ? gate_to_word(deep_d) :
    (rd_addr == CLK_CFG_OFS) ? {31'h0000_0000, auto_d} :
    (rd_addr == IRQ_STATUS_OFS) ? {28'h000_0000, sts_d} :
    (rd_addr == IRQ_MASK_OFS) ? {28'h000_0000, mask_d} :
    32'h0000_0000;

  // ********************************************************
  // flops
  // ********************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase & HWRITE;
      wr_addr_q <= addr_phase ? rd_addr : wr_addr_q;
      rdata_q <= (addr_phase & ~HWRITE) ? rd_word : rdata_q;
    end
  end

  // reset value keeps only named fields, so all gates start at zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      run_q <= word_to_gate(GATE_RESET);
      sleep_q <= word_to_gate(GATE_RESET);
      deep_q <= word_to_gate(GATE_RESET);
      auto_q <= AUTO_GATE_RESET;
    end else begin
      run_q <= run_d;
      sleep_q <= sleep_d;
      deep_q <= deep_d;
      auto_q <= auto_d;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sts_q <= IRQ_RESET;
      mask_q <= IRQ_RESET;
      en_q <= {NUM_UNITS{1'b0}};
      rate_q <= RATE_125K;
      ksps_q <= KSPS_125;
      pwr_q <= PWR_RUN;
    end else begin
      sts_q <= sts_d;
      mask_q <= mask_d;
      en_q <= en_d;
      rate_q <= applied.rate;
      ksps_q <= ksps_d;
      pwr_q <= pwr_d;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign UNIT_FAULT = fault;
  assign UNIT_CLK_EN = en_q;
  assign ADC_RATE_SEL = rate_q;
  assign ADC_RATE_KSPS = ksps_q;
  assign IRQ = |(sts_q & mask_q);

endmodule : periph_clk_gate

`default_nettype wire
